// ===== logic/fpes_top.sv
// Program/erase suspend control: serial opcode capture, suspend records, gating.
// Assumes an outer decoder classifies other commands and an array engine
// that advances only while engine_go is high.
`timescale 1ns/1ps
module fpes_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic reset_pin_b,
  input wire fpes_pkg::fpes_op_s op_req,
  input wire logic op_done,
  input wire fpes_pkg::fpes_cmd_s cmd,
  input wire logic [fpes_pkg::ADDR_W-1:0] rd_addr,
  output fpes_pkg::fpes_flags_s flags,
  output logic ready,
  output logic engine_go,
  output logic prog_abort,
  output logic cmd_accept,
  output logic cmd_reject,
  output logic rd_undefined,
  output fpes_pkg::fpes_undef_s undef_es,
  output fpes_pkg::fpes_undef_s undef_ps
);

  localparam int AW = fpes_pkg::ADDR_W;
  localparam int SW = fpes_pkg::ADDR_W - fpes_pkg::SECT_LSB;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSPENDING, ST_RESUMING} fpes_state_e;

  function automatic logic [SW-1:0] fpes_sect(input logic [AW-1:0] a);
    fpes_sect = a[AW-1:fpes_pkg::SECT_LSB];
  endfunction

  function automatic logic fpes_cmd_ok(input fpes_pkg::fpes_cmd_e c, input logic b2,
                                       input logic ps1, input logic ps2, input logic es);
    logic any;
    any = ps1 | ps2 | es;
    case (c)
      fpes_pkg::CMD_BUF_WRITE: fpes_cmd_ok = b2 ? ~ps2 : ~ps1;
      fpes_pkg::CMD_B2M_NOERASE: fpes_cmd_ok = ~(ps1 | ps2);
      fpes_pkg::CMD_MTB1_NOERASE: fpes_cmd_ok = ~(ps1 | ps2);
      fpes_pkg::CMD_PROG_ERASE: fpes_cmd_ok = ~any;
      fpes_pkg::CMD_REWRITE: fpes_cmd_ok = ~any;
      fpes_pkg::CMD_ERASE: fpes_cmd_ok = ~any;
      fpes_pkg::CMD_PROT_CHANGE: fpes_cmd_ok = ~any;
      default: fpes_cmd_ok = 1'b1;
    endcase
  endfunction

  // Link side, clocked by the serial clock; frame logic held reset while deselected
  logic link_rst_b;
  logic [2:0] bit_cnt_reg;
  logic byte_done_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_hold_reg;
  logic link_tog_reg;
  logic byte_last;

  assign link_rst_b = rst_b & ~cs_b;
  assign byte_last = ~byte_done_reg & (bit_cnt_reg == 3'h7);

  always_ff @(posedge sck or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      shift_reg <= 8'h00;
    end
    else
    begin
      shift_reg <= {shift_reg[6:0], mosi};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      byte_done_reg <= byte_done_reg | byte_last;
    end
  end

  // Opcode is held stable until the next frame's first byte, so the core copies it safely
  always_ff @(posedge sck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_hold_reg <= fpes_pkg::OPC_RST_VAL;
      link_tog_reg <= 1'b0;
    end
    else if (byte_last)
    begin
      op_hold_reg <= {shift_reg[6:0], mosi};
      link_tog_reg <= ~link_tog_reg;
    end
  end

  // Core side
  logic [2:0] sync_out;
  logic cs_s;
  logic tog_s;
  logic rpin_s;

  fpes_sync #(.WIDTH(3), .RST_VAL(3'h5)) u_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .din({reset_pin_b, link_tog_reg, cs_b}),
    .dout(sync_out)
  );

  assign cs_s = sync_out[0];
  assign tog_s = sync_out[1];
  assign rpin_s = sync_out[2];

  fpes_state_e state_reg;
  fpes_state_e state_next;
  logic tog_prev_reg;
  logic rpin_prev_reg;
  logic pend_reg;
  logic [7:0] opc_reg;
  logic [fpes_pkg::LAT_W-1:0] lat_reg;
  logic [fpes_pkg::LAT_W-1:0] lat_next;
  logic es_v_reg;
  logic ps_v_reg;
  logic res_prog_reg;
  fpes_pkg::fpes_rec_s es_rec_reg;
  fpes_pkg::fpes_rec_s ps_rec_reg;
  fpes_pkg::fpes_rec_s run_rec_reg;
  logic prog_abort_reg;
  logic cmd_accept_reg;
  logic cmd_reject_reg;
  logic rd_undef_reg;
  fpes_pkg::fpes_undef_s undef_es_reg;
  fpes_pkg::fpes_undef_s undef_ps_reg;

  wire tog_edge = tog_s ^ tog_prev_reg;
  wire frame_end = pend_reg & cs_s;
  wire pend_next = tog_edge | (pend_reg & ~cs_s);
  wire [7:0] opc_next = tog_edge ? op_hold_reg : opc_reg;
  wire susp_go = frame_end & (opc_reg == fpes_pkg::OPC_SUSPEND);
  wire res_go = frame_end & (opc_reg == fpes_pkg::OPC_RESUME);
  wire cmd_rst = cmd.valid & (cmd.cls == fpes_pkg::CMD_RESET);
  wire flash_rst = (rpin_prev_reg & ~rpin_s) | cmd_rst;
  wire run_is_prog = (run_rec_reg.kind == fpes_pkg::OP_PROG_B1) |
                     (run_rec_reg.kind == fpes_pkg::OP_PROG_B2);
  wire req_is_prog = (op_req.kind == fpes_pkg::OP_PROG_B1) |
                     (op_req.kind == fpes_pkg::OP_PROG_B2);
  wire prog_blocked = req_is_prog & es_v_reg &
                      (fpes_sect(op_req.addr) == fpes_sect(es_rec_reg.addr));
  wire start_idle = op_req.start & (state_reg == ST_IDLE) & ~flash_rst;
  wire start_ok = start_idle & ~prog_blocked;
  // A suspend during resume latency is dropped
  wire susp_take = susp_go & (state_reg == ST_RUN);
  wire susp_done = (state_reg == ST_SUSPENDING) & (lat_reg == '0);
  wire res_take = res_go & (state_reg == ST_IDLE) & (es_v_reg | ps_v_reg);
  wire res_done = (state_reg == ST_RESUMING) & (lat_reg == '0);
  wire ps1 = ps_v_reg & (ps_rec_reg.kind == fpes_pkg::OP_PROG_B1);
  wire ps2 = ps_v_reg & (ps_rec_reg.kind == fpes_pkg::OP_PROG_B2);

  // Records keep the whole address; the sector bits define what is suspended
  wire es_v_next = ~flash_rst & ((susp_done & ~run_is_prog) |
                   (es_v_reg & ~(res_done & ~res_prog_reg)));
  wire ps_v_next = ~flash_rst & ((susp_done & run_is_prog) |
                   (ps_v_reg & ~(res_done & res_prog_reg)));
  wire fpes_pkg::fpes_rec_s es_rec_next = (susp_done & ~run_is_prog) ? run_rec_reg : es_rec_reg;
  wire fpes_pkg::fpes_rec_s ps_rec_next = (susp_done & run_is_prog) ? run_rec_reg : ps_rec_reg;
  // Program record wins on resume when both are held
  wire fpes_pkg::fpes_rec_s res_rec = ps_v_reg ? ps_rec_reg : es_rec_reg;
  wire fpes_pkg::fpes_rec_s run_rec_next = start_ok ? {op_req.kind, op_req.addr} :
                                           res_take ? res_rec : run_rec_reg;
  wire res_prog_next = res_take ? ps_v_reg : res_prog_reg;
  wire cmd_ok = fpes_cmd_ok(cmd.cls, cmd.buf_two, ps1, ps2, es_v_reg);
  wire rd_hit = (es_v_reg & (fpes_sect(rd_addr) == fpes_sect(es_rec_reg.addr))) |
                (ps_v_reg & (fpes_sect(rd_addr) == fpes_sect(ps_rec_reg.addr)));
  wire fpes_pkg::fpes_undef_s uedn = {flash_rst & es_v_reg,
    es_rec_reg.kind == fpes_pkg::OP_ERASE_SECTOR, es_rec_reg.addr};
  wire fpes_pkg::fpes_undef_s updn = {flash_rst & ps_v_reg, 1'b0, ps_rec_reg.addr};

  always_comb
  begin
    state_next = state_reg;
    lat_next = (lat_reg != '0) ? lat_reg - 1'b1 : lat_reg;
    if (flash_rst)
      state_next = ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (start_ok)
            state_next = ST_RUN;
          else if (res_take)
          begin
            state_next = ST_RESUMING;
            lat_next = fpes_pkg::LAT_W'(fpes_pkg::RES_CYC - 1);
          end
        ST_RUN:
          if (susp_take)
          begin
            state_next = ST_SUSPENDING;
            lat_next = fpes_pkg::LAT_W'(fpes_pkg::SUSP_CYC - 1);
          end
          else if (op_done)
            state_next = ST_IDLE;
        ST_SUSPENDING:
          if (lat_reg == '0)
            state_next = ST_IDLE;
        ST_RESUMING:
          if (lat_reg == '0)
            state_next = ST_RUN;
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      lat_reg <= '0;
      tog_prev_reg <= 1'b0;
      rpin_prev_reg <= 1'b1;
      pend_reg <= 1'b0;
      opc_reg <= fpes_pkg::OPC_RST_VAL;
    end
    else
    begin
      state_reg <= state_next;
      lat_reg <= lat_next;
      tog_prev_reg <= tog_s;
      rpin_prev_reg <= rpin_s;
      pend_reg <= pend_next;
      opc_reg <= opc_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      es_v_reg <= 1'b0;
      ps_v_reg <= 1'b0;
      res_prog_reg <= 1'b0;
      es_rec_reg <= '0;
      ps_rec_reg <= '0;
      run_rec_reg <= '0;
    end
    else
    begin
      es_v_reg <= es_v_next;
      ps_v_reg <= ps_v_next;
      res_prog_reg <= res_prog_next;
      es_rec_reg <= es_rec_next;
      ps_rec_reg <= ps_rec_next;
      run_rec_reg <= run_rec_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_abort_reg <= 1'b0;
      cmd_accept_reg <= 1'b0;
      cmd_reject_reg <= 1'b0;
      rd_undef_reg <= 1'b0;
      undef_es_reg <= '0;
      undef_ps_reg <= '0;
    end
    else
    begin
      prog_abort_reg <= start_idle & prog_blocked;
      cmd_accept_reg <= cmd.valid & cmd_ok;
      cmd_reject_reg <= cmd.valid & ~cmd_ok;
      rd_undef_reg <= rd_hit;
      undef_es_reg <= uedn;
      undef_ps_reg <= updn;
    end
  end

  assign flags = {es_v_reg, ps1, ps2};
  assign ready = (state_reg == ST_IDLE);
  assign engine_go = (state_reg == ST_RUN);
  assign prog_abort = prog_abort_reg;
  assign cmd_accept = cmd_accept_reg;
  assign cmd_reject = cmd_reject_reg;
  assign rd_undefined = rd_undef_reg;
  assign undef_es = undef_es_reg;
  assign undef_ps = undef_ps_reg;

  localparam int SUSP_BOUND = fpes_pkg::SUSP_CYC + 2;
  localparam int RES_BOUND = fpes_pkg::RES_CYC + 2;

  susp_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    susp_take |=> ##[0:SUSP_BOUND] (flash_rst || (ready && (run_is_prog ? ps_v_reg : es_v_reg))))
    else $error("suspend did not take effect in time");
  flag_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(es_v_reg) || $rose(ps_v_reg)) |-> ready && !engine_go)
    else $error("flag set without ready");
  susp_record_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (susp_done && !flash_rst) |=> (run_is_prog ? ps_rec_reg : es_rec_reg) == $past(run_rec_reg))
    else $error("suspend record differs from interrupted operation");
  read_undef_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (es_v_reg && $stable(es_v_reg) && !ps_v_reg &&
     fpes_sect(rd_addr) == fpes_sect(es_rec_reg.addr)) |=> rd_undefined)
    else $error("read into suspended sector not marked");
  prog_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (start_idle && prog_blocked) |=> prog_abort && ready)
    else $error("program into erase suspended sector not aborted");
  dual_sector_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (es_v_reg && ps_v_reg) |-> fpes_sect(es_rec_reg.addr) != fpes_sect(ps_rec_reg.addr))
    else $error("dual suspend in one sector");
  reset_undef_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (flash_rst && es_v_reg && es_rec_reg.kind == fpes_pkg::OP_ERASE_SECTOR)
    |=> undef_es.valid && undef_es.whole_sector && !flags.erase_suspend_flag)
    else $error("reset did not spoil erase suspended sector");
  reset_page_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (flash_rst && ps_v_reg) |=> undef_ps.valid && !undef_ps.whole_sector && !ps_v_reg)
    else $error("reset did not abort program suspend");
  erase_reject_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd.valid && cmd.cls == fpes_pkg::CMD_ERASE && (es_v_reg || ps_v_reg))
    |=> cmd_reject && !cmd_accept)
    else $error("erase accepted while suspended");
  read_accept_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd.valid && (cmd.cls == fpes_pkg::CMD_READ_ARRAY || cmd.cls == fpes_pkg::CMD_READ_PROT))
    |=> cmd_accept)
    else $error("read refused while suspended");
  nowrite_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd.valid && cmd.cls == fpes_pkg::CMD_B2M_NOERASE && ps_v_reg) |=> cmd_reject)
    else $error("program accepted under program suspend");
  resume_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (res_take && es_v_reg && ps_v_reg && !flash_rst)
    |-> ##[1:RES_BOUND] (flash_rst || (!ps_v_reg && es_v_reg && engine_go)))
    else $error("program did not resume first");

  susp_resume_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    susp_done ##[1:100] res_take);
  dual_susp_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    es_v_reg && ps_v_reg);
  reset_abort_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    flash_rst && es_v_reg);

endmodule

// ===== logic/fpes_pkg.sv
// Constants and types for the program/erase suspend block.
// Assumes a 100 MHz core clock and a byte-wide array address of 19 bits.
// Notes on behaviour
// - Suspend takes effect after frame end, bounded latency
// - Suspension sets program or erase flag, shows ready
// - Suspension covers only the interrupted operation's sector
// - Reads into a suspended sector give undefined data
// - Continuous read undefined only inside suspended sector
// - Program into erase-suspended sector is aborted
// - Program suspend allowed under erase suspend, both flagged
// - Reset under sector erase suspend spoils sector
// - Reset under page-level suspend spoils only page
// - Status reads and similar accepted while suspended
// - Array and buffer reads always accepted while suspended
// - Buffer-to-memory program without erase: erase suspend only
// - Program through buffer one without erase: erase only
// - Programs with built-in erase rejected while suspended
// - Page rewrite and read-modify-write rejected while suspended
// - All erase commands rejected while suspended
// - Protection change commands rejected while suspended
// - Protection register read accepted while suspended
// - Resume clears flag, shows busy; program resumes first
package fpes_pkg;

  localparam int CLK_NS = 10;
  localparam int SUSP_LAT_NS = 5000;
  localparam int RES_LAT_NS = 5000;
  // Longest times, so counts round down, never below one cycle
  localparam int SUSP_CYC = (SUSP_LAT_NS / CLK_NS) < 1 ? 1 : (SUSP_LAT_NS / CLK_NS);
  localparam int RES_CYC = (RES_LAT_NS / CLK_NS) < 1 ? 1 : (RES_LAT_NS / CLK_NS);
  localparam int LAT_W = 16;

  localparam logic [7:0] OPC_SUSPEND = 8'hb0;
  localparam logic [7:0] OPC_RESUME = 8'hd0;
  localparam logic [7:0] OPC_RST_VAL = 8'h00;

  localparam int ADDR_W = 19;
  localparam int SECT_LSB = 16;
  localparam int PAGE_LSB = 8;

  typedef enum logic [1:0] {
    OP_PROG_B1,
    OP_PROG_B2,
    OP_ERASE_PAGE,
    OP_ERASE_SECTOR
  } fpes_op_e;

  typedef enum logic [3:0] {
    CMD_READ_ARRAY,
    CMD_READ_BUF,
    CMD_READ_STATUS,
    CMD_READ_PROT,
    CMD_BUF_WRITE,
    CMD_B2M_NOERASE,
    CMD_MTB1_NOERASE,
    CMD_PROG_ERASE,
    CMD_REWRITE,
    CMD_ERASE,
    CMD_PROT_CHANGE,
    CMD_RESET,
    CMD_OTHER
  } fpes_cmd_e;

  typedef struct packed {
    logic valid;
    fpes_cmd_e cls;
    logic buf_two;
  } fpes_cmd_s;

  typedef struct packed {
    logic start;
    fpes_op_e kind;
    logic [ADDR_W-1:0] addr;
  } fpes_op_s;

  typedef struct packed {
    fpes_op_e kind;
    logic [ADDR_W-1:0] addr;
  } fpes_rec_s;

  typedef struct packed {
    logic erase_suspend_flag;
    logic prog_suspend_buf_one_flag;
    logic prog_suspend_buf_two_flag;
  } fpes_flags_s;

  typedef struct packed {
    logic valid;
    logic whole_sector;
    logic [ADDR_W-1:0] addr;
  } fpes_undef_s;

endpackage

// ===== logic/fpes_sync.sv
// Three-stage synchroniser for pins and cross-domain levels.
// Assumes inputs change slowly compared to the destination clock.
`timescale 1ns/1ps
module fpes_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_next;

  // A bit moves only once stages two and three agree, filtering one-cycle glitches
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : dout[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout <= out_next;
    end
  end

endmodule

// ===== verification/fpes_host.sv
// Host serial controller model: sends opcode frames, mode 0, MSB first.
// Assumes the bench calls send() and waits for it to return.
`timescale 1ns/1ps
module fpes_host (
  output logic sck,
  output logic cs_b,
  output logic mosi
);
  initial
  begin
    sck = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  // Link clock of 64 ns runs only inside a frame
  task automatic send(input logic [15:0] data, input int nbits);
    int i;
    cs_b = 1'b0;
    for (i = 15; i > 15 - nbits; i--)
    begin
      mosi = data[i];
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    #32 cs_b = 1'b1;
    // Released line has no pull, so it must not keep the last bit
    mosi = ~mosi;
    #100;
  endtask
endmodule

// ===== verification/flash_program_erase_suspend_test.sv
// Self-checking bench for the suspend block, one task per scenario.
// Assumes the fixed package latencies; the host model drives the link.
`timescale 1ns/1ps
module flash_program_erase_suspend_test;
  logic ref_clk, rst_b, reset_pin_b, op_done;
  logic sck, cs_b, mosi;
  fpes_pkg::fpes_op_s op_req;
  fpes_pkg::fpes_cmd_s cmd;
  logic [fpes_pkg::ADDR_W-1:0] rd_addr;
  fpes_pkg::fpes_flags_s flags;
  logic ready, engine_go, prog_abort, cmd_accept, cmd_reject, rd_undefined;
  fpes_pkg::fpes_undef_s undef_es, undef_ps;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam int LIMIT = 20000;

  fpes_host host (.sck(sck), .cs_b(cs_b), .mosi(mosi));

  fpes_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .mosi(mosi),
    .reset_pin_b(reset_pin_b), .op_req(op_req), .op_done(op_done), .cmd(cmd),
    .rd_addr(rd_addr), .flags(flags), .ready(ready), .engine_go(engine_go),
    .prog_abort(prog_abort), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .rd_undefined(rd_undefined), .undef_es(undef_es), .undef_ps(undef_ps));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      $display("Error at %0t: run hung", $time);
      conclude();
    end
  end

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic start_op(input fpes_pkg::fpes_op_e kind, input logic [18:0] addr);
    @(negedge ref_clk);
    op_req = '{1'b1, kind, addr};
    @(negedge ref_clk);
    op_req.start = 1'b0;
  endtask

  task automatic do_cmd(input fpes_pkg::fpes_cmd_e cls, input logic b2, input logic acc);
    @(negedge ref_clk);
    cmd = '{1'b1, cls, b2};
    @(negedge ref_clk);
    cmd.valid = 1'b0;
    chk(cmd_accept === acc && cmd_reject === !acc, "command verdict wrong");
  endtask

  // Suspend frame with a trailing junk byte that must be ignored
  task automatic suspend(input logic [2:0] exp);
    int n;
    n = 0;
    host.send(16'hb0a5, 16);
    @(negedge ref_clk);
    chk(engine_go === 1'b0 && ready === 1'b0, "engine not halted");
    while (ready !== 1'b1 && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(n > fpes_pkg::SUSP_CYC - 20 && n < fpes_pkg::SUSP_CYC + 20, "suspend latency");
    chk(flags === exp, "suspend flags wrong");
  endtask

  task automatic t_erase_suspend();
    start_op(fpes_pkg::OP_ERASE_SECTOR, 19'h21234);
    chk(engine_go === 1'b1 && ready === 1'b0, "erase did not start");
    tick(5);
    suspend(3'b100);
    $display("test erase suspend done");
  endtask

  task automatic t_reads();
    logic [18:0] a[4] = '{19'h1ffff, 19'h20000, 19'h2ffff, 19'h30000};
    logic e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int i;
    for (i = 0; i < 4; i++)
    begin
      rd_addr = a[i];
      tick(1);
      chk(rd_undefined === e[i], "read range flag wrong");
    end
    $display("test read ranges done");
  endtask

  task automatic t_abort();
    start_op(fpes_pkg::OP_PROG_B1, 19'h20100);
    chk(prog_abort === 1'b1 && engine_go === 1'b0, "program not aborted");
    tick(1);
    chk(ready === 1'b1 && flags === 3'b100, "abort disturbed state");
    $display("test program abort done");
  endtask

  task automatic t_table_es();
    fpes_pkg::fpes_cmd_e c[12] = '{fpes_pkg::CMD_READ_ARRAY, fpes_pkg::CMD_READ_BUF,
      fpes_pkg::CMD_READ_STATUS, fpes_pkg::CMD_READ_PROT, fpes_pkg::CMD_BUF_WRITE,
      fpes_pkg::CMD_BUF_WRITE, fpes_pkg::CMD_B2M_NOERASE, fpes_pkg::CMD_MTB1_NOERASE,
      fpes_pkg::CMD_PROG_ERASE, fpes_pkg::CMD_REWRITE, fpes_pkg::CMD_ERASE,
      fpes_pkg::CMD_PROT_CHANGE};
    logic b[12] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic e[12] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    int i;
    for (i = 0; i < 12; i++)
      do_cmd(c[i], b[i], e[i]);
    do_cmd(fpes_pkg::CMD_OTHER, 1'b0, 1'b1);
    $display("test erase suspend table done");
  endtask

  task automatic t_nested();
    start_op(fpes_pkg::OP_PROG_B2, 19'h50040);
    chk(engine_go === 1'b1, "program under erase suspend refused");
    tick(5);
    suspend(3'b101);
    do_cmd(fpes_pkg::CMD_BUF_WRITE, 1'b1, 1'b0);
    do_cmd(fpes_pkg::CMD_BUF_WRITE, 1'b0, 1'b1);
    do_cmd(fpes_pkg::CMD_B2M_NOERASE, 1'b0, 1'b0);
    do_cmd(fpes_pkg::CMD_MTB1_NOERASE, 1'b0, 1'b0);
    do_cmd(fpes_pkg::CMD_READ_BUF, 1'b1, 1'b1);
    rd_addr = 19'h5ff00;
    tick(1);
    chk(rd_undefined === 1'b1, "program sector readable");
    $display("test nested suspend done");
  endtask

  task automatic t_resume();
    int n;
    n = 0;
    host.send(16'hd000, 8);
    @(negedge ref_clk);
    chk(ready === 1'b0, "busy not shown on resume");
    while (engine_go !== 1'b1 && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(n > fpes_pkg::RES_CYC - 20 && n < fpes_pkg::RES_CYC + 20, "resume latency");
    chk(flags === 3'b100, "program did not resume first");
    op_done = 1'b1;
    tick(1);
    op_done = 1'b0;
    tick(2);
    chk(ready === 1'b1 && flags === 3'b100, "program end state");
    $display("test resume done");
  endtask

  task automatic wait_undef();
    int n;
    n = 0;
    while (undef_es.valid !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic t_reset_pin();
    @(negedge ref_clk);
    reset_pin_b = 1'b0;
    wait_undef();
    chk(undef_es.valid === 1'b1, "sector spoil missing");
    chk(undef_es.whole_sector === 1'b1 && undef_es.addr === 19'h21234, "sector spoil");
    chk(undef_ps.valid === 1'b0, "stray program spoil");
    reset_pin_b = 1'b1;
    tick(2);
    chk(flags === 3'b000 && ready === 1'b1, "suspend not aborted");
    $display("test reset pin done");
  endtask

  // Page-level erase suspend plus a buffer one program suspend, then reset by command
  task automatic t_page_reset();
    start_op(fpes_pkg::OP_ERASE_PAGE, 19'h60300);
    tick(5);
    suspend(3'b100);
    start_op(fpes_pkg::OP_PROG_B1, 19'h10080);
    chk(engine_go === 1'b1, "program beside page suspend refused");
    tick(5);
    suspend(3'b110);
    do_cmd(fpes_pkg::CMD_BUF_WRITE, 1'b0, 1'b0);
    do_cmd(fpes_pkg::CMD_BUF_WRITE, 1'b1, 1'b1);
    @(negedge ref_clk);
    cmd = '{1'b1, fpes_pkg::CMD_RESET, 1'b0};
    @(negedge ref_clk);
    cmd.valid = 1'b0;
    wait_undef();
    chk(undef_es.valid === 1'b1, "page spoil missing");
    chk(undef_es.whole_sector === 1'b0 && undef_es.addr === 19'h60300, "page spoil");
    chk(undef_ps.valid === 1'b1 && undef_ps.whole_sector === 1'b0, "program spoil");
    chk(undef_ps.addr === 19'h10080, "program spoil page");
    tick(2);
    chk(flags === 3'b000 && ready === 1'b1, "page suspend not aborted");
    $display("test page reset done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    reset_pin_b = 1'b1;
    op_req = '0;
    op_done = 1'b0;
    cmd = '0;
    rd_addr = '0;
    tick(16);
    rst_b = 1'b1;
    tick(4);
    t_erase_suspend();
    t_reads();
    t_abort();
    t_table_es();
    t_nested();
    t_resume();
    t_reset_pin();
    t_page_reset();
    conclude();
  end
endmodule
